// file: verilog/iotl_osc_ctrl.v
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "iotl_consts.vh"
module iotl_osc_ctrl (
    input  wire        clock,
    input  wire        reset,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    input  wire        clockRecoveryOn,
    input  wire [15:0] timer2Count,
    input  wire [15:0] timer3Count,
    output reg  [4:0]  hfPeriodCode,
    output reg         lfClockOut,
    output reg         lfSettledFlag,
    output reg         timer2Capture,
    output reg         timer3Capture
);
    reg  [4:0]  hfTrim_q;
    reg         lfOn_q;
    reg  [3:0]  lfFineTune_q;
    reg  [1:0]  lfDivideSelect_q;
    reg  [1:0]  captureMode_q;
    reg  [15:0] t2Reload_q;
    reg  [15:0] t3Reload_q;
    reg         lfPrev_q;
    wire        lfOut;
    wire        lfSettled;
    wire        lfFall;
    wire        lfRise;
    wire        request;
    wire        writeLow;
    reg  [31:0] readData;

    iotl_lf_osc lfOsc (
        .clock        (clock),
        .reset        (reset),
        .enable       (lfOn_q),
        .fineTune     (lfFineTune_q),
        .divideSelect (lfDivideSelect_q),
        .lfOut        (lfOut),
        .settled      (lfSettled)
    );

    assign request  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign writeLow = request && wb_we_i && wb_sel_i[0];
    assign lfFall   = captureMode_q[0] && lfPrev_q && !lfOut;
    assign lfRise   = captureMode_q[1] && !lfPrev_q && lfOut;

    always @* begin
        if (wb_adr_i == `IOTL_ADDR_LF_CTRL) begin
            readData = {24'h000000, lfOn_q, lfSettled, lfFineTune_q, lfDivideSelect_q};
        end else if (wb_adr_i == `IOTL_ADDR_HF_TRIM) begin
            // reads return hfTrim_q whatever clockRecoveryOn is
            readData = {27'h0000000, hfTrim_q};
        end else if (wb_adr_i == `IOTL_ADDR_CAPTURE) begin
            readData = {30'h00000000, captureMode_q};
        end else if (wb_adr_i == `IOTL_ADDR_T2_RELOAD) begin
            readData = {16'h0000, t2Reload_q};
        end else if (wb_adr_i == `IOTL_ADDR_T3_RELOAD) begin
            readData = {16'h0000, t3Reload_q};
        end else begin
            readData = 32'h00000000;
        end
    end

    always @(posedge clock) begin
        if (reset) begin
            wb_ack_o         <= 1'b0;
            wb_dat_o         <= 32'h00000000;
            hfTrim_q         <= `IOTL_HF_TRIM_RESET;
            lfOn_q           <= 1'b0;
            lfFineTune_q     <= `IOTL_LF_FINE_RESET;
            lfDivideSelect_q <= 2'b00;
            captureMode_q    <= 2'b00;
        end else begin
            wb_ack_o <= request;
            if (request) begin
                wb_dat_o <= readData;
            end
            if (writeLow && wb_adr_i == `IOTL_ADDR_LF_CTRL) begin
                lfOn_q           <= wb_dat_i[`IOTL_BIT_LF_ON];
                lfFineTune_q     <= wb_dat_i[5:2];
                lfDivideSelect_q <= wb_dat_i[1:0];
            end else if (writeLow && wb_adr_i == `IOTL_ADDR_HF_TRIM) begin
                hfTrim_q <= wb_dat_i[4:0];
            end else if (writeLow && wb_adr_i == `IOTL_ADDR_CAPTURE) begin
                captureMode_q <= wb_dat_i[1:0];
            end
        end
    end

    // lfOut is produced on this clock, so no synchroniser is needed
    always @(posedge clock) begin
        if (reset) begin
            lfPrev_q      <= 1'b0;
            t2Reload_q    <= 16'h0000;
            t3Reload_q    <= 16'h0000;
            timer2Capture <= 1'b0;
            timer3Capture <= 1'b0;
            hfPeriodCode  <= `IOTL_HF_TRIM_RESET;
            lfClockOut    <= 1'b0;
            lfSettledFlag <= 1'b0;
        end else begin
            lfPrev_q      <= lfOut;
            hfPeriodCode  <= hfTrim_q;
            lfClockOut    <= lfOut;
            lfSettledFlag <= lfSettled;
            timer2Capture <= lfFall;
            timer3Capture <= lfRise;
            if (lfFall) begin
                t2Reload_q <= timer2Count;
            end
            if (lfRise) begin
                t3Reload_q <= timer3Count;
            end
        end
    end
endmodule
`default_nettype wire

// file: verilog/iotl_consts.vh
// Function
// - five-bit period trim in low bits; zero fastest, all ones slowest
// - period trim resets to a factory value giving the nominal frequency
// - period trim contents are undefined while clock recovery is on
// - low-frequency source runs at a nominal 80 kHz before division
// - divide select: 00 by eight, 01 by four, 10 by two, 11 by one
// - four-bit fine tune in bits five to two; zero fastest
// - capture mode: falling edge to second timer, rising edge to third
// - each capture copies timer count bytes into its reload bytes
`ifndef IOTL_CONSTS_VH
`define IOTL_CONSTS_VH
`define IOTL_ADDR_LF_CTRL     8'h86
`define IOTL_ADDR_HF_TRIM     8'hB3
`define IOTL_ADDR_CAPTURE     8'hC0
`define IOTL_ADDR_T2_RELOAD   8'hC1
`define IOTL_ADDR_T3_RELOAD   8'hC2
`define IOTL_BIT_LF_ON        7
`define IOTL_BIT_LF_SETTLED   6
`define IOTL_HF_TRIM_RESET    5'h10
`define IOTL_LF_CTRL_RESET    6'h20
`define IOTL_LF_FINE_RESET    4'h8
`define IOTL_SYS_CLK_KHZ      32'h000186A0
`define IOTL_LF_NOMINAL_KHZ   32'h00000050
`define IOTL_LF_SETTLE_HALVES 4'h8
`endif

// file: verilog/iotl_lf_osc.v
`timescale 1ns/1ps
`default_nettype none
`include "iotl_consts.vh"
// behavioural low-frequency source: toggles a level after a tuned half period
module iotl_lf_osc (
    input  wire        clock,
    input  wire        reset,
    input  wire        enable,
    input  wire [3:0]  fineTune,
    input  wire [1:0]  divideSelect,
    output reg         lfOut,
    output reg         settled
);
    localparam integer HALF_BASE = `IOTL_SYS_CLK_KHZ / (2 * `IOTL_LF_NOMINAL_KHZ);
    reg [15:0] count_q;
    reg [3:0]  halves_q;
    reg [2:0]  div_q;
    reg        raw_q;
    wire [15:0] halfLen;
    // larger code, longer half period
    assign halfLen = HALF_BASE[15:0] - 16'h0008 + {11'h000, fineTune, 1'b0};
    always @(posedge clock) begin
        if (reset || !enable) begin
            count_q  <= 16'h0000;
            halves_q <= 4'h0;
            div_q    <= 3'h0;
            raw_q    <= 1'b0;
            lfOut    <= 1'b0;
            settled  <= 1'b0;
        end else begin
            // counter runs 0 .. halfLen-1, so one half period is exactly halfLen cycles
            if (count_q >= halfLen - 16'h0001) begin
                count_q <= 16'h0000;
                raw_q   <= ~raw_q;
                if (!raw_q) begin
                    div_q <= div_q + 3'h1;
                end
                if (halves_q != 4'hF) begin
                    halves_q <= halves_q + 4'h1;
                end
            end else begin
                count_q <= count_q + 16'h0001;
            end
            case (divideSelect)
                2'b00:   lfOut <= div_q[2];
                2'b01:   lfOut <= div_q[1];
                2'b10:   lfOut <= div_q[0];
                default: lfOut <= raw_q;
            endcase
            settled <= (halves_q >= `IOTL_LF_SETTLE_HALVES);
        end
    end
endmodule
`default_nettype wire

// file: dv/iotl_osc_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module iotl_osc_ctrl_props (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic [4:0]  hfPeriodCode,
    input wire logic        lfClockOut,
    input wire logic        lfSettledFlag,
    input wire logic        timer2Capture,
    input wire logic        timer3Capture
);
    wire logic tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rd = tk && !wb_we_i;
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
    a_ack_answer: assert property (tk |=> wb_ack_o) else $error("no ack");
    a_reset_vals: assert property ($fell(reset) |-> hfPeriodCode == 5'h10 && !lfSettledFlag)
        else $error("bad reset value");
    // the trim reaches the output pin one cycle after the register itself
    a_trim_write: assert property (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'hB3 |-> ##2
        hfPeriodCode == $past(wb_dat_i[4:0], 2)) else $error("trim not written");
    a_trim_read: assert property (rd && wb_adr_i == 8'hB3 |=> wb_dat_o[4:0] == hfPeriodCode)
        else $error("trim readback");
    a_unmapped_zero: assert property (rd && wb_adr_i == 8'h55 |=> wb_dat_o == 32'h0)
        else $error("unmapped read");
    a_t2_falling: assert property (timer2Capture |-> !lfClockOut && $past(lfClockOut))
        else $error("t2 edge");
    a_t3_rising: assert property (timer3Capture |-> lfClockOut && !$past(lfClockOut))
        else $error("t3 edge");
    c_settled: cover property ($rose(lfSettledFlag));
    c_t2: cover property (timer2Capture);
    c_t3: cover property (timer3Capture);
endmodule
bind iotl_osc_ctrl iotl_osc_ctrl_props uProps (.*);
`default_nettype wire

// file: dv/iotl_osc_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module iotl_osc_ctrl_tb_top;
    logic        clock = 0, reset = 1, cyc = 0, stb = 0, we = 0, ack, lfClk, lfSet, t2Cap, t3Cap;
    logic [7:0]  adr = 0;
    logic [3:0]  sel = 0;
    logic [4:0]  hfCode;
    logic [15:0] cnt = 0;
    logic [31:0] dat = 0, datO, q, r1;
    logic [23:0] rows [5] = '{24'hB30000, 24'hB31F1F, 24'h863F3F, 24'h864000, 24'h55FF00};
    int          fail_count = 0, n_compared = 0, ticks = 0;
    iotl_osc_ctrl uut (.clock(clock), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(datO),
        .wb_ack_o(ack), .clockRecoveryOn(1'b0), .timer2Count(cnt), .timer3Count(cnt),
        .hfPeriodCode(hfCode), .lfClockOut(lfClk), .lfSettledFlag(lfSet),
        .timer2Capture(t2Cap), .timer3Capture(t3Cap));
    always #5 clock = ~clock;
    task report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cnt <= cnt + 16'h1;
        ticks <= ticks + 1;
        if (ticks == 60000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // ack and read data are taken at the rising edge, as sampled before it
    task wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
            output logic [31:0] o);
        @(posedge clock);
        {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, 24'h0, d, s};
        do @(posedge clock); while (ack !== 1'b1);
        o = datO;
        {cyc, stb, we} <= 3'b000;
    endtask
    // skip one capture so a divider change never spoils the measured interval
    task cap(input logic s, input logic [15:0] e);
        for (int k = 0; k < 3; k++) begin
            do @(posedge clock); while ((s ? t3Cap : t2Cap) !== 1'b1);
            chk("lfClk", {31'h0, s}, {31'h0, lfClk});
            r1 = q;
            wb(0, s ? 8'hC2 : 8'hC1, 8'h0, 4'h1, q);
        end
        chk("period", {16'h0, e}, {16'h0, 16'(q[15:0] - r1[15:0])});
    endtask
    initial begin
        repeat (20) @(posedge clock);
        reset <= 0;
        chk("hfCode", 32'h10, {27'h0, hfCode});
        wb(0, 8'h86, 8'h0, 4'h1, q);
        chk("lfCtrl", 32'h20, {24'h0, q[7:0]});
        foreach (rows[i]) begin
            wb(1, rows[i][23:16], rows[i][15:8], 4'h1, q);
            wb(0, rows[i][23:16], 8'h0, 4'h1, q);
            chk("row", {24'h0, rows[i][7:0]}, {24'h0, q[7:0]});
        end
        wb(1, 8'hB3, 8'h0A, 4'h0, q);
        chk("hfCode", 32'h1F, {27'h0, hfCode});
        wb(1, 8'h86, 8'h83, 4'h1, q);
        do @(posedge clock); while (lfSet !== 1'b1);
        wb(0, 8'h86, 8'h0, 4'h1, q);
        chk("lfCtrl", 32'hC3, {24'h0, q[7:0]});
        wb(1, 8'hC0, 8'h03, 4'h1, q);
        // fine code 0: half period 625 - 8 cycles, undivided then divided by eight
        cap(1, 16'h04D2);
        wb(1, 8'h86, 8'h80, 4'h1, q);
        cap(0, 16'h2690);
        wb(1, 8'h86, 8'h0, 4'h1, q);
        wb(0, 8'h86, 8'h0, 4'h1, q);
        chk("lfCtrl", 32'h0, {24'h0, q[7:0]});
        // second reset in mid-run must restore the factory trim and control value
        reset <= 1;
        repeat (2) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        chk("hfCode", 32'h10, {27'h0, hfCode});
        wb(0, 8'h86, 8'h0, 4'h1, q);
        chk("lfCtrl", 32'h20, {24'h0, q[7:0]});
        report_and_stop();
    end
endmodule
`default_nettype wire
